// >>> swpmc_defs.vh
// Constants for the switch power-mode controller.
// Assumes a 25 MHz MCLK and word-aligned AHB-Lite register access.
//
// Overview of operation
// - Mode field 00 normal, 01 energy detect, 10 soft power-down, 11 reserved.
// - Power-up or hardware reset loads the mode field with normal code.
// - Normal mode runs every clock, powers PHY and MAC, accepts host access.
// - No cable energy beyond go-sleep time moves energy detect to low power.
// - Low power disables everything but the receiver energy detector.
// - Energy seen in low power returns to the normal-power state.
// - Normal-power state of energy detect lets ports send and receive.
// - Low power keeps sending a 120 ns line pulse once per second.
// - Soft power-down stops internal clocks and powers off PHYs and MACs.
// - Host access during soft power-down wakes and resets all registers.
// - Port control register bit 3 powers down that port's PHY.
// - PHY control register 0 bit 11 also powers down that PHY.
// - Low-power idle runs separately per direction at 100 Mb/s.
// - During low-power idle a port's MAC clock is gated off once both directions idle; switch clocks keep running.
// - Idle entry and exit keep link status and never lose frames.
// - MAC stays full duplex but carrier sense defers during idle.
// - Switch logic requests idle, passed to the PHY over the MII.
// - Partner idle flag raised while the link partner signals idle.
// - Request sends assert-idle; after release, normal idle then wake delay.
// - Receive assert-idle keeps idle shown and sets flag; else clears it.
// - Idle requested only when both ends advertise the capability.
`ifndef SWPMC_DEFS_VH
`define SWPMC_DEFS_VH

`define SWPMC_CLK_PERIOD_NS 40
// Register indices; byte address is four times the index
`define SWPMC_IDX_GPMC      8'h0e
`define SWPMC_IDX_SLEEP     8'h0f
`define SWPMC_IDX_PORT1     8'h1d
`define SWPMC_IDX_PORT2     8'h2d
`define SWPMC_IDX_PORT3     8'h3d
`define SWPMC_IDX_PORT4     8'h4d
`define SWPMC_IDX_STATUS    8'h50
`define SWPMC_IDX_EEE       8'h51
`define SWPMC_IDX_PHY0      8'h60
`define SWPMC_IDX_PHY3      8'h63
// Fields
`define SWPMC_MODE_HI       4
`define SWPMC_MODE_LO       3
`define SWPMC_PORT_PD_BIT   3
`define SWPMC_PHY_PD_BIT    11
// Mode codes
`define SWPMC_MODE_NORMAL   2'h0
`define SWPMC_MODE_ED       2'h1
`define SWPMC_MODE_SOFTPD   2'h2
// Reset values
`define SWPMC_GPMC_RST      8'h00
`define SWPMC_SLEEP_RST     8'h50
`define SWPMC_PORT_RST      8'h00
`define SWPMC_PHY_RST       16'h0000
`define SWPMC_EEE_RST       4'h0
// Timing
`define SWPMC_TICK_US       1000
`define SWPMC_BEACON_MS     1000
`define SWPMC_PULSE_NS      120
`define SWPMC_WAKE_NS       30000
// Assert-idle receive encoding on a nibble MII
`define SWPMC_LPI_RXD       4'h1
// AHB
`define SWPMC_HTRANS_NONSEQ 2'h2

`endif

// >>> swpmc_top.v
// Power-mode controller of a four-port switch: modes, energy detect,
// port power-down and low-power idle signalling, AHB-Lite registers.
// Assumes the MII and switch requests run on MCLK; energy pins are async.
`timescale 1ns/100ps
`include "swpmc_defs.vh"

module swpmc_top #(
  parameter TICK_CYC   = `SWPMC_TICK_US * 1000 / `SWPMC_CLK_PERIOD_NS,
  parameter BEACON_CYC = `SWPMC_BEACON_MS * 1000 / `SWPMC_CLK_PERIOD_NS
                         * 1000
) (
  input  wire        MCLK,          // System clock
  input  wire        RST_N,         // Async reset, active low
  input  wire        HSEL,          // AHB slave select
  input  wire [31:0] HADDR,         // AHB address
  input  wire [1:0]  HTRANS,        // AHB transfer type
  input  wire        HWRITE,        // AHB write
  input  wire [2:0]  HSIZE,         // AHB size, word only
  input  wire [31:0] HWDATA,        // AHB write data
  input  wire        HREADY,        // AHB bus ready
  output reg  [31:0] HRDATA,        // AHB read data
  output reg         HREADYOUT,     // AHB slave ready
  output reg         HRESP,         // AHB response, always OKAY
  input  wire [3:0]  ENERGY_DET,    // Cable energy per port, async
  input  wire [3:0]  LPI_REQ,       // Switch idle request per port
  input  wire [3:0]  LP_EEE_ABLE,   // Partner advertised idle ability
  input  wire [3:0]  RX_DV,         // PHY receive valid per port
  input  wire [3:0]  RX_ER,         // PHY receive error per port
  input  wire [15:0] RXD,           // PHY receive nibbles per port
  output reg  [3:0]  TX_LPI,        // Assert-idle encoding on transmit
  output reg  [3:0]  TX_DEFER,      // Carrier sense defer to MAC
  output reg  [3:0]  RX_DV_MAC,     // Receive valid mapped to MAC
  output reg  [3:0]  RX_ER_MAC,     // Receive error mapped to MAC
  output reg  [3:0]  PARTNER_IDLE_FLAG, // Partner signalling idle
  output reg  [3:0]  PHY_PWR_DN,    // PHY power-down per port
  output reg  [3:0]  MAC_CLK_EN,    // MAC clock enable per port
  output reg         MAC_PWR_DN,    // All MACs powered off
  output reg         CORE_CLK_EN,   // Internal clocks running
  output reg         ED_LOW_POWER,  // Energy-detect low-power state
  output reg         LINE_PULSE     // Energy-detect line beacon
);

  localparam PULSE_CYC = (`SWPMC_PULSE_NS + `SWPMC_CLK_PERIOD_NS - 1)
                         / `SWPMC_CLK_PERIOD_NS;
  localparam WAKE_CYC  = (`SWPMC_WAKE_NS + `SWPMC_CLK_PERIOD_NS - 1)
                         / `SWPMC_CLK_PERIOD_NS;
  localparam ED_NORMAL = 1'b0;
  localparam ED_LOW    = 1'b1;

  // ****************************************************************
  // Registers and bus slave
  // ****************************************************************
  reg  [7:0]  gpmc_q;
  reg  [7:0]  sleep_q;
  reg  [7:0]  port_q [0:3];
  reg  [15:0] phy_q  [0:3];
  reg  [3:0]  eee_adv_q;
  reg         wr_pend_q;
  reg  [7:0]  wr_idx_q;
  reg         ed_state_q;
  reg  [3:0]  energy_q;

  wire [1:0]  mode     = gpmc_q[`SWPMC_MODE_HI:`SWPMC_MODE_LO];
  wire        soft_pd  = (mode == `SWPMC_MODE_SOFTPD);
  wire        ed_mode  = (mode == `SWPMC_MODE_ED);
  // Reserved code falls through as normal
  wire        acc      = HSEL & HREADY & HTRANS[1];
  wire        wake     = acc & soft_pd;
  wire [7:0]  acc_idx  = HADDR[9:2];
  wire        ed_low   = ed_mode & (ed_state_q == ED_LOW);

  reg  [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (acc_idx)
      `SWPMC_IDX_GPMC:   rd_d[7:0] = gpmc_q;
      `SWPMC_IDX_SLEEP:  rd_d[7:0] = sleep_q;
      `SWPMC_IDX_PORT1:  rd_d[7:0] = port_q[0];
      `SWPMC_IDX_PORT2:  rd_d[7:0] = port_q[1];
      `SWPMC_IDX_PORT3:  rd_d[7:0] = port_q[2];
      `SWPMC_IDX_PORT4:  rd_d[7:0] = port_q[3];
      `SWPMC_IDX_EEE:    rd_d[3:0] = eee_adv_q;
      `SWPMC_IDX_STATUS: rd_d[15:0] = {PARTNER_IDLE_FLAG, PHY_PWR_DN,
                                       energy_q, ed_low, 1'b0, mode};
      default: begin
        if (acc_idx >= `SWPMC_IDX_PHY0 && acc_idx <= `SWPMC_IDX_PHY3)
          rd_d[15:0] = phy_q[acc_idx[1:0]];
      end
    endcase
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      // Waking access completes but is otherwise discarded
      wr_pend_q <= acc & HWRITE & ~soft_pd;
      wr_idx_q  <= acc_idx;
      if (acc && !HWRITE)
        HRDATA <= soft_pd ? 32'h0000_0000 : rd_d;
    end
  end

  integer i;
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      gpmc_q    <= `SWPMC_GPMC_RST;
      sleep_q   <= `SWPMC_SLEEP_RST;
      eee_adv_q <= `SWPMC_EEE_RST;
      for (i = 0; i < 4; i = i + 1) begin
        port_q[i] <= `SWPMC_PORT_RST;
        phy_q[i]  <= `SWPMC_PHY_RST;
      end
    end else if (wake) begin
      gpmc_q    <= `SWPMC_GPMC_RST;
      sleep_q   <= `SWPMC_SLEEP_RST;
      eee_adv_q <= `SWPMC_EEE_RST;
      for (i = 0; i < 4; i = i + 1) begin
        port_q[i] <= `SWPMC_PORT_RST;
        phy_q[i]  <= `SWPMC_PHY_RST;
      end
    end else if (wr_pend_q && !soft_pd) begin
      case (wr_idx_q)
        `SWPMC_IDX_GPMC:  gpmc_q    <= HWDATA[7:0];
        `SWPMC_IDX_SLEEP: sleep_q   <= HWDATA[7:0];
        `SWPMC_IDX_PORT1: port_q[0] <= HWDATA[7:0];
        `SWPMC_IDX_PORT2: port_q[1] <= HWDATA[7:0];
        `SWPMC_IDX_PORT3: port_q[2] <= HWDATA[7:0];
        `SWPMC_IDX_PORT4: port_q[3] <= HWDATA[7:0];
        `SWPMC_IDX_EEE:   eee_adv_q <= HWDATA[3:0];
        default: begin
          if (wr_idx_q >= `SWPMC_IDX_PHY0 && wr_idx_q <= `SWPMC_IDX_PHY3)
            phy_q[wr_idx_q[1:0]] <= HWDATA[15:0];
        end
      endcase
    end
  end

  // ****************************************************************
  // Energy input synchronisers
  // ****************************************************************
  reg [3:0] en_s1_q;
  reg [3:0] en_s2_q;
  reg [3:0] en_s3_q;
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      en_s1_q  <= 4'h0;
      en_s2_q  <= 4'h0;
      en_s3_q  <= 4'h0;
      energy_q <= 4'h0;
    end else begin
      en_s1_q <= ENERGY_DET;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      // Accept a change once two stages agree
      energy_q <= (en_s2_q & en_s3_q) | (energy_q & (en_s2_q | en_s3_q));
    end
  end

  // ****************************************************************
  // Energy-detect state machine
  // ****************************************************************
  reg [31:0] tick_cnt_q;
  reg [8:0]  quiet_q;
  reg        ed_state_d;
  wire       tick = (tick_cnt_q == TICK_CYC - 1);
  wire       any_energy = |energy_q;

  always @* begin
    ed_state_d = ed_state_q;
    case (ed_state_q)
      ED_NORMAL: begin
        if (quiet_q > {1'b0, sleep_q})
          ed_state_d = ED_LOW;
      end
      ED_LOW: begin
        if (any_energy)
          ed_state_d = ED_NORMAL;
      end
      default: ed_state_d = ED_NORMAL;
    endcase
    if (!ed_mode)
      ed_state_d = ED_NORMAL;
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ed_state_q <= ED_NORMAL;
      tick_cnt_q <= 32'h0000_0000;
      quiet_q    <= 9'h000;
    end else begin
      ed_state_q <= ed_state_d;
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (!ed_mode || any_energy || ed_state_q == ED_LOW)
        quiet_q <= 9'h000;
      else if (tick && quiet_q != 9'h1ff)
        quiet_q <= quiet_q + 9'h001;
    end
  end

  // ****************************************************************
  // Line beacon in low power
  // ****************************************************************
  reg [31:0] beacon_q;
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      beacon_q   <= 32'h0000_0000;
      LINE_PULSE <= 1'b0;
    end else if (ed_low) begin
      beacon_q   <= (beacon_q == BEACON_CYC - 1) ? 32'h0000_0000
                                                 : beacon_q + 32'h0000_0001;
      LINE_PULSE <= (beacon_q < PULSE_CYC);
    end else begin
      beacon_q   <= 32'h0000_0000;
      LINE_PULSE <= 1'b0;
    end
  end

  // ****************************************************************
  // Global power outputs
  // ****************************************************************
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CORE_CLK_EN  <= 1'b1;
      MAC_PWR_DN   <= 1'b0;
      ED_LOW_POWER <= 1'b0;
    end else begin
      CORE_CLK_EN  <= ~soft_pd & ~ed_low;
      MAC_PWR_DN   <= soft_pd | ed_low;
      ED_LOW_POWER <= ed_low;
    end
  end

  // ****************************************************************
  // Per-port power-down and low-power idle
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      reg  [9:0] wake_q;
      wire       eee_ok  = eee_adv_q[p] & LP_EEE_ABLE[p];
      wire       req     = LPI_REQ[p] & eee_ok;
      wire       rx_lpi  = ~RX_DV[p] & RX_ER[p] &
                           (RXD[4*p+3:4*p] == `SWPMC_LPI_RXD);
      wire       pd      = port_q[p][`SWPMC_PORT_PD_BIT] |
                           phy_q[p][`SWPMC_PHY_PD_BIT];

      always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
          wake_q               <= 10'h000;
          TX_LPI[p]            <= 1'b0;
          TX_DEFER[p]          <= 1'b0;
          PARTNER_IDLE_FLAG[p] <= 1'b0;
          RX_DV_MAC[p]         <= 1'b0;
          RX_ER_MAC[p]         <= 1'b0;
          PHY_PWR_DN[p]        <= 1'b0;
          MAC_CLK_EN[p]        <= 1'b1;
        end else begin
          // Transmit direction, independent of receive
          TX_LPI[p] <= req;
          if (req)
            wake_q <= WAKE_CYC[9:0];
          else if (wake_q != 10'h000)
            wake_q <= wake_q - 10'h001;
          TX_DEFER[p] <= req | (wake_q > 10'h001);
          // Receive direction
          PARTNER_IDLE_FLAG[p] <= rx_lpi & eee_ok;
          RX_DV_MAC[p] <= RX_DV[p];
          RX_ER_MAC[p] <= RX_ER[p] & ~rx_lpi;
          PHY_PWR_DN[p] <= pd | soft_pd | ed_low;
          MAC_CLK_EN[p] <= ~pd & ~soft_pd & ~ed_low &
                           ~(req & rx_lpi & eee_ok);
        end
      end
    end
  endgenerate

endmodule

// >>> swpmc_chk.sv
// Assertion checker for the switch power-mode controller.
// Bound to swpmc_top; watches top-level ports only.
`timescale 1ns/100ps
`include "swpmc_defs.vh"

module swpmc_chk #(
  parameter TICK_CYC   = 4,
  parameter BEACON_CYC = 20
) (
  input wire        MCLK,              // Clock
  input wire        RST_N,             // Reset
  input wire        HREADYOUT,         // Ready
  input wire        HRESP,             // Response
  input wire [3:0]  LPI_REQ,           // Idle request
  input wire [3:0]  LP_EEE_ABLE,       // Partner ability
  input wire [3:0]  RX_DV,             // Rx valid
  input wire [3:0]  RX_ER,             // Rx error
  input wire [15:0] RXD,               // Rx nibbles
  input wire [3:0]  TX_LPI,            // Tx idle
  input wire [3:0]  TX_DEFER,          // Defer
  input wire [3:0]  PARTNER_IDLE_FLAG, // Partner idle
  input wire [3:0]  MAC_CLK_EN,        // MAC clocks
  input wire        MAC_PWR_DN,        // MAC off
  input wire        CORE_CLK_EN,       // Core clocks
  input wire        ED_LOW_POWER,      // Low power
  input wire        LINE_PULSE         // Beacon
);
  // ******
  // Receive assert-idle decode
  // ******
  wire [3:0] rx_lpi;
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_enc
      assign rx_lpi[p] = !RX_DV[p] && RX_ER[p]
                         && RXD[4*p+:4] == `SWPMC_LPI_RXD;
    end
  endgenerate

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_ready_zero_wait: assert property ($past(RST_N) |-> HREADYOUT)
    else $error("slave ready dropped");
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("response not okay");
  a_softpd_clocks: assert property (MAC_PWR_DN |->
    !CORE_CLK_EN && MAC_CLK_EN == 4'h0) else $error("clocks run in power-down");
  a_lowpwr_gates: assert property (ED_LOW_POWER |-> MAC_CLK_EN == 4'h0)
    else $error("MAC clocks on in low power");
  a_pulse_width: assert property ($rose(LINE_PULSE) |->
    LINE_PULSE[*3] ##1 !LINE_PULSE) else $error("beacon width wrong");
  a_pulse_lowpwr: assert property ($rose(LINE_PULSE) |-> ED_LOW_POWER)
    else $error("beacon outside low power");
  a_lpi_capable: assert property ((TX_LPI &
    ~($past(LPI_REQ) & $past(LP_EEE_ABLE))) == 4'h0)
    else $error("idle sent without cause");
  a_defer_idle: assert property (($past(TX_LPI) & TX_LPI & ~TX_DEFER) == 4'h0)
    else $error("no defer while idle");
  a_defer_hold: assert property ($fell(TX_LPI[0]) |-> TX_DEFER[0][*8])
    else $error("defer dropped at wake");
  a_flag_cause: assert property ((PARTNER_IDLE_FLAG &
    ~($past(rx_lpi) & $past(LP_EEE_ABLE))) == 4'h0)
    else $error("partner flag without cause");
endmodule

bind swpmc_top swpmc_chk #(.TICK_CYC(TICK_CYC), .BEACON_CYC(BEACON_CYC)) u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .LPI_REQ(LPI_REQ), .LP_EEE_ABLE(LP_EEE_ABLE), .RX_DV(RX_DV),
  .RX_ER(RX_ER), .RXD(RXD), .TX_LPI(TX_LPI), .TX_DEFER(TX_DEFER),
  .PARTNER_IDLE_FLAG(PARTNER_IDLE_FLAG), .MAC_CLK_EN(MAC_CLK_EN),
  .MAC_PWR_DN(MAC_PWR_DN), .CORE_CLK_EN(CORE_CLK_EN),
  .ED_LOW_POWER(ED_LOW_POWER), .LINE_PULSE(LINE_PULSE));

// >>> swpmc_phy_mdl.sv
// Far-side PHY receive model: normal idle or assert-idle per port.
// Assumes bench commands that change just after a rising edge.
`timescale 1ns/100ps

module swpmc_phy_mdl (
  input  wire        clk,    // Clock
  input  wire [3:0]  lpi_on, // Send assert-idle
  output reg  [3:0]  rx_dv,  // Rx valid
  output reg  [3:0]  rx_er,  // Rx error
  output reg  [15:0] rxd     // Rx nibbles
);
  reg [3:0] pat = 4'h5;
  integer   p;
  initial {rx_dv, rx_er, rxd} = 24'h0;
  always @(posedge clk) begin
    pat <= pat + 4'h7;
    rx_dv <= 4'h0;
    rx_er <= lpi_on;
    for (p = 0; p < 4; p = p + 1)
      rxd[4*p+:4] <= lpi_on[p] ? 4'h1 : pat ^ p[3:0];
  end
endmodule

// >>> swpmc_top_tb.sv
// Self-checking bench for the switch power-mode controller.
// Assumes 25 MHz MCLK; receive MII comes from swpmc_phy_mdl.
`timescale 1ns/100ps
`include "swpmc_defs.vh"

module swpmc_top_tb;
  reg         MCLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  reg  [31:0] HADDR = 32'h0, HWDATA = 32'h0, r, d, e, a;
  reg  [1:0]  HTRANS = 2'h0;
  reg  [3:0]  ENERGY_DET = 4'h0, LPI_REQ = 4'h0, LP_EEE_ABLE = 4'h0;
  reg  [3:0]  lpi_on = 4'h0;
  wire [31:0] HRDATA;
  wire        HREADYOUT, HRESP, MAC_PWR_DN, CORE_CLK_EN;
  wire        ED_LOW_POWER, LINE_PULSE;
  wire [3:0]  RX_DV, RX_ER, TX_LPI, TX_DEFER, PARTNER_IDLE_FLAG;
  wire [3:0]  PHY_PWR_DN, MAC_CLK_EN, RX_DV_MAC, RX_ER_MAC;
  wire [15:0] RXD;
  integer     mdl [0:255];
  integer     err_count = 0, total_checks = 0, i, n, seed;

  always #20 MCLK = ~MCLK;

  swpmc_top #(.TICK_CYC(4), .BEACON_CYC(20)) DUT (
    .MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .ENERGY_DET(ENERGY_DET), .LPI_REQ(LPI_REQ),
    .LP_EEE_ABLE(LP_EEE_ABLE), .RX_DV(RX_DV), .RX_ER(RX_ER), .RXD(RXD),
    .TX_LPI(TX_LPI), .TX_DEFER(TX_DEFER), .RX_DV_MAC(RX_DV_MAC),
    .RX_ER_MAC(RX_ER_MAC),
    .PARTNER_IDLE_FLAG(PARTNER_IDLE_FLAG), .PHY_PWR_DN(PHY_PWR_DN),
    .MAC_CLK_EN(MAC_CLK_EN), .MAC_PWR_DN(MAC_PWR_DN),
    .CORE_CLK_EN(CORE_CLK_EN), .ED_LOW_POWER(ED_LOW_POWER),
    .LINE_PULSE(LINE_PULSE));

  swpmc_phy_mdl u_phy (.clk(MCLK), .lpi_on(lpi_on), .rx_dv(RX_DV),
    .rx_er(RX_ER), .rxd(RXD));

  // ******
  // Bus, model and check tasks
  // ******
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  task chk(input [31:0] s, input [31:0] x, input [8*10:1] nm);
    begin
      total_checks = total_checks + 1;
      if (s !== x) begin
        err_count = err_count + 1;
        $display("[FAIL] %0s exp %h seen %h", nm, x, s);
      end
    end
  endtask

  task mreset;
    integer k;
    begin
      for (k = 0; k < 256; k = k + 1) mdl[k] = 0;
      mdl[`SWPMC_IDX_SLEEP] = `SWPMC_SLEEP_RST;
    end
  endtask

  task wrdy;
    integer k;
    begin
      k = 0;
      @(posedge MCLK);
      while (HREADYOUT !== 1'b1 && k < 50) begin
        k = k + 1;
        @(posedge MCLK);
      end
    end
  endtask

  task ahb(input w, input [7:0] i, input [31:0] dd);
    begin
      @(posedge MCLK);
      HSEL <= 1'b1;
      HTRANS <= `SWPMC_HTRANS_NONSEQ;
      HADDR <= {22'h0, i, 2'h0};
      HWRITE <= w;
      wrdy;
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= dd;
      wrdy;
      r = HRDATA;
    end
  endtask

  task wr(input [7:0] i, input [31:0] dd);
    begin
      ahb(1'b1, i, dd);
      if (mdl[`SWPMC_IDX_GPMC][4:3] == 2) mreset;
      else mdl[i] = dd & (i >= `SWPMC_IDX_PHY0 ? 32'hffff : 32'hff);
    end
  endtask

  task rd(input [7:0] i, input [8*10:1] nm);
    reg [31:0] x;
    begin
      x = mdl[i];
      if (mdl[`SWPMC_IDX_GPMC][4:3] == 2) begin
        x = 0;
        mreset;
      end
      ahb(1'b0, i, 32'h0);
      chk(r, x, nm);
    end
  endtask

  task waitfor(input integer lim);
    begin
      n = 0;
      while (ED_LOW_POWER !== 1'b1 && n < lim) begin
        @(negedge MCLK);
        n = n + 1;
      end
    end
  endtask

  initial begin
    #400000;
    err_count = err_count + 1;
    finish_test;
  end

  initial begin
    seed = $urandom(65464);
    mreset;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    @(negedge MCLK);
    chk({CORE_CLK_EN, MAC_PWR_DN, PHY_PWR_DN}, 6'h20, "reset_out");
    rd(`SWPMC_IDX_GPMC, "mode");
    rd(`SWPMC_IDX_SLEEP, "sleep");
    ahb(1'b1, 8'h40, 32'hff);
    rd(8'h40, "unmapped");
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      d = $urandom;
      e = $urandom;
      wr(`SWPMC_IDX_PORT1 + i * 16, d);
      wr(`SWPMC_IDX_PHY0 + i, e);
      repeat (2) @(negedge MCLK);
      chk(PHY_PWR_DN[i], d[3] | e[11], "phy_pd");
      rd(`SWPMC_IDX_PORT1 + i * 16, "port");
      rd(`SWPMC_IDX_PHY0 + i, "phy_ctl");
    end
    $display("test port power done");
    wr(`SWPMC_IDX_GPMC, 8'h10);
    repeat (3) @(negedge MCLK);
    chk({CORE_CLK_EN, MAC_PWR_DN}, 2'b01, "softpd");
    rd(`SWPMC_IDX_PORT1, "wake_rd");
    rd(`SWPMC_IDX_PORT1, "port");
    rd(`SWPMC_IDX_GPMC, "mode");
    repeat (2) @(negedge MCLK);
    chk({CORE_CLK_EN, MAC_PWR_DN, PHY_PWR_DN}, 6'h20, "awake");
    $display("test soft power-down done");
    wr(`SWPMC_IDX_GPMC, 8'h18);
    repeat (40) @(negedge MCLK);
    chk({CORE_CLK_EN, MAC_PWR_DN, ED_LOW_POWER}, 3'b100, "reserved");
    rd(`SWPMC_IDX_GPMC, "mode");
    $display("test reserved mode done");
    wr(`SWPMC_IDX_SLEEP, 8'h02);
    wr(`SWPMC_IDX_GPMC, 8'h08);
    waitfor(100);
    chk(n > 8 && n < 30, 1, "sleep_time");
    n = 0;
    while (LINE_PULSE !== 1'b1 && n < 60) begin
      @(negedge MCLK);
      n = n + 1;
    end
    chk(n < 60, 1, "beacon");
    ahb(1'b0, `SWPMC_IDX_STATUS, 32'h0);
    chk(r, 32'h0000_0f09, "status");
    @(posedge MCLK);
    ENERGY_DET <= 4'h1 << ($urandom % 4);
    repeat (12) @(negedge MCLK);
    chk({ED_LOW_POWER, PHY_PWR_DN}, 5'h0, "ed_normal");
    wr(`SWPMC_IDX_GPMC, 8'h00);
    $display("test energy detect done");
    a = $urandom % 16;
    wr(`SWPMC_IDX_EEE, a);
    for (i = 0; i < 40; i = i + 1) begin
      @(posedge MCLK);
      LPI_REQ <= $urandom % 16;
      LP_EEE_ABLE <= $urandom % 16;
      lpi_on <= $urandom % 16;
      repeat (3) @(negedge MCLK);
      chk(TX_LPI, LPI_REQ & LP_EEE_ABLE & a[3:0], "tx_lpi");
      chk(PARTNER_IDLE_FLAG, lpi_on & LP_EEE_ABLE & a[3:0], "lp_flag");
      chk({RX_DV_MAC, RX_ER_MAC}, 8'h00, "rx_map");
    end
    wr(`SWPMC_IDX_EEE, 32'hf);
    @(posedge MCLK);
    LPI_REQ <= 4'hf;
    LP_EEE_ABLE <= 4'hf;
    repeat (4) @(posedge MCLK);
    LPI_REQ <= 4'h0;
    repeat (600) @(negedge MCLK);
    chk(TX_DEFER, 4'hf, "defer_hold");
    repeat (300) @(negedge MCLK);
    chk(TX_DEFER, 4'h0, "defer_end");
    $display("test low-power idle done");
    finish_test;
  end
endmodule
